/* File: ecp_pkg.sv */
// constants, register map and field layout of the ECP parallel port
//
// Summary of operation
// (R01) every port word moved to or from software is eight bits wide
// (R02) one shared sixteen-byte FIFO serves compat, ECP address/data and test FIFOs
// (R03) status, control and extended control registers answer in every mode
// (R04) config B reads back the interrupt line and DMA channel chosen for the port
// (R05) address/RLE entry: bit 7 tells channel address from run-length count
// (R06) no negotiation in hardware; automatic DMA burst channel both directions
// (R07) compatibility FIFO mode strobes each byte out by hardware handshake
// (R08) a run-length byte makes the next data byte repeat the given count
// (R09) outgoing data is never compressed; incoming RLE is always expanded
// (R10) forward: strobe latches byte into peripheral, interlocked with busy
// (R11) forward: peripheral drops busy when it can accept data
// (R12) reverse: peripheral busy level marks command versus data byte
// (R13) reverse: peripheral ack low marks valid data, interlocked with host ack
// (R14) reverse: host ack low requests a byte and throttles the peripheral
// (R15) forward: host ack tells channel address from data on the data lines
// (R16) init low puts the channel in reverse, high in forward
// (R17) peripheral answers reverse request with nAckReverse low, interlocked
// (R18) host drives data lines only when nAckReverse permits
// (R19) peripheral drives data only in ECP mode, host ack low, select-in high
// (R20) select-in stays deasserted the whole time the port is in ECP mode
// (R21) a low fault input raises an error interrupt condition
// (R22) peripheral request during forward is only a hint; host keeps direction
// (R23) ECP mode write at data offset queues an address/RLE tagged entry
// (R24) full and empty flags track FIFO occupancy on every push and pop
package ecp_pkg;
  // ---------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------------
  localparam int unsigned    ADDR_W     = 13;
  localparam logic [10:0]    IDX_DATA   = 11'h000;
  localparam logic [10:0]    IDX_STATUS = 11'h001;
  localparam logic [10:0]    IDX_CTRL   = 11'h002;
  localparam logic [10:0]    IDX_FIFO   = 11'h400;
  localparam logic [10:0]    IDX_CFGB   = 11'h401;
  localparam logic [10:0]    IDX_ECR    = 11'h402;
  // ---------------------------------------------------------------------
  // modes, fields, reset values
  // ---------------------------------------------------------------------
  localparam logic [2:0]     MODE_SPP   = 3'h0;
  localparam logic [2:0]     MODE_BIDIR = 3'h1;
  localparam logic [2:0]     MODE_COMPAT = 3'h2;
  localparam logic [2:0]     MODE_ECP   = 3'h3;
  localparam logic [2:0]     MODE_TEST  = 3'h6;
  localparam logic [2:0]     MODE_CFG   = 3'h7;
  localparam int unsigned    CTL_STROBE = 0;
  localparam int unsigned    CTL_AUTOFD = 1;
  localparam int unsigned    CTL_INIT   = 2;
  localparam int unsigned    CTL_SELIN  = 3;
  localparam int unsigned    CTL_DIR    = 5;
  localparam int unsigned    TAG_BIT    = 7;
  localparam logic [7:0]     CFGA_VALUE = 8'h10;
  localparam logic [7:0]     DATA_RESET = 8'h00;
  localparam logic [5:0]     CTRL_RESET = 6'h00;
  localparam logic [2:0]     MODE_RESET = 3'h0;
  localparam int unsigned    PWORD_W    = 8;
  localparam int unsigned    FIFO_DEPTH = 16;
endpackage

/* File: ecp_port.sv */
// ECP parallel port: APB registers, shared FIFO, forward/reverse handshakes
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module ecp_port #(
  parameter int unsigned DEPTH = ecp_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ecp_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // chip configuration
  input  wire logic [2:0]                  cfg_irq,
  input  wire logic [2:0]                  cfg_dma,
  // system side events
  output logic                             fault_intr,
  output logic                             dma_req,
  // parallel cable
  input  wire logic [7:0]                  pd_in,
  output logic      [7:0]                  pd_out,
  output logic                             pd_oe_n,
  output logic                             strobe_n,
  output logic                             host_ack,
  output logic                             init_n,
  output logic                             select_in_n,
  input  wire logic                        ack_n,
  input  wire logic                        busy,
  input  wire logic                        ack_reverse_n,
  input  wire logic                        select,
  input  wire logic                        fault_n
);
  import ecp_pkg::*;

  localparam int unsigned PW = $clog2(DEPTH);

  typedef enum logic [2:0] {
    ST_IDLE, ST_F_SETUP, ST_F_STROBE, ST_F_HOLD, ST_R_REQ, ST_R_TAKE, ST_R_REPEAT
  } ecp_st_t;

  typedef struct packed {
    logic [12:0]               s1;
    logic [12:0]               s2;
    logic [7:0]                data;
    logic [5:0]                ctrl;
    logic [2:0]                mode;
    logic                      fault_interrupt_enable_n;
    logic                      dma_enable;
    logic                      service_interrupt;
    logic [DEPTH-1:0][8:0]     mem;
    logic [PW-1:0]             wp;
    logic [PW-1:0]             rp;
    logic [PW:0]               cnt;
    logic [7:0]                last;
    ecp_st_t                   st;
    logic [7:0]                rx;
    logic                      rx_cmd;
    logic                      rle_pend;
    logic [6:0]                rle;
    logic [7:0]                tx;
    logic                      tx_addr;
    logic [7:0]                prdata;
    logic                      pready;
    logic                      pslverr;
    logic                      fault_intr;
    logic                      dma_req;
    logic [7:0]                pd_out;
    logic                      pd_oe_n;
    logic                      strobe_n;
    logic                      host_ack;
    logic                      init_n;
    logic                      select_in_n;
  } ecp_state_t;

  // ---------------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------------
  function automatic logic fifo_mode(input logic [2:0] m);
    return (m == MODE_COMPAT) || (m == MODE_ECP);
  endfunction

  // direction is forced out in spp and compat modes
  function automatic logic eff_dir(input logic [2:0] m, input logic [5:0] c);
    return (m != MODE_SPP) && (m != MODE_COMPAT) && c[CTL_DIR];
  endfunction

  function automatic logic mapped(input logic [10:0] i, input logic [2:0] m);
    return (i == IDX_DATA) || (i == IDX_STATUS) || (i == IDX_CTRL) || (i == IDX_ECR) ||
           ((i == IDX_FIFO) && (fifo_mode(m) || m == MODE_TEST || m == MODE_CFG)) ||
           ((i == IDX_CFGB) && (m == MODE_CFG));
  endfunction

  ecp_state_t q;
  ecp_state_t n;

  logic [10:0] idx;
  logic        dir;
  logic        full;
  logic        empty;
  logic [7:0]  head;
  logic        busy_s;
  logic        ack_n_s;
  logic        ackrev_s;
  logic        fault_s;
  logic        select_s;
  logic [7:0]  pd_s;

  assign idx      = paddr[12:2];
  assign dir      = eff_dir(q.mode, q.ctrl);
  assign full     = (q.cnt == (PW+1)'(DEPTH));  // R24
  assign empty    = (q.cnt == '0);              // R24
  assign head     = q.mem[q.rp][7:0];
  assign pd_s     = q.s2[12:5];
  assign ack_n_s  = q.s2[4];
  assign busy_s   = q.s2[3];
  assign ackrev_s = q.s2[2];
  assign select_s = q.s2[1];
  assign fault_s  = q.s2[0];

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  always_comb begin
    logic       setup;
    logic       wr;
    logic       rd;
    logic       push;
    logic       pop;
    logic [8:0] pin;
    setup = psel && !penable;
    wr    = psel && penable && q.pready && pwrite;
    rd    = psel && penable && q.pready && !pwrite;
    push  = 1'b0;
    pop   = 1'b0;
    pin   = '0;
    n     = q;

    // cable inputs pass two flops before use
    n.s1 = {pd_in, ack_n, busy, ack_reverse_n, select, fault_n};
    n.s2 = q.s1;

    // apb: answer is computed in the setup cycle, one access cycle always
    n.pready  = setup;
    n.pslverr = setup && !mapped(idx, q.mode);
    if (setup) begin
      case (idx)
        IDX_DATA:   n.prdata = (q.mode == MODE_SPP || q.mode == MODE_BIDIR) ? pd_s : q.data;
        IDX_STATUS: n.prdata = {!busy_s, ack_n_s, ackrev_s, select_s, fault_s, 3'h0}; // R03
        IDX_CTRL:   n.prdata = {2'h0, q.ctrl};                                        // R03
        IDX_FIFO:   n.prdata = (q.mode == MODE_CFG) ? CFGA_VALUE : (empty ? q.last : head);
        IDX_CFGB:   n.prdata = {1'b0, q.fault_intr, cfg_irq, cfg_dma};                // R04
        IDX_ECR:    n.prdata = {q.mode, q.fault_interrupt_enable_n, q.dma_enable,
                                q.service_interrupt, full, empty};                    // R03 R24
        default:    n.prdata = 8'h00;
      endcase
      // refused accesses return zero whatever the index would decode to
      if (!mapped(idx, q.mode)) begin
        n.prdata = 8'h00;
      end
    end

    // software writes; only the low byte of the bus is a port word
    if (wr) begin
      case (idx)
        IDX_DATA: begin
          if (q.mode == MODE_SPP || q.mode == MODE_BIDIR) begin
            n.data = pwdata[7:0];
          end else if (q.mode == MODE_ECP && !dir && !full) begin
            push = 1'b1;                                             // R23
            pin  = {1'b1, pwdata[7:0]};
          end
        end
        IDX_CTRL: n.ctrl = pwdata[5:0];
        IDX_FIFO: begin
          if (((fifo_mode(q.mode) && !dir) || q.mode == MODE_TEST) && !full) begin
            push = 1'b1;                                             // R01 R02
            pin  = {1'b0, pwdata[7:0]};
          end
        end
        IDX_ECR: begin
          n.mode                     = pwdata[7:5];
          n.fault_interrupt_enable_n = pwdata[4];
          n.dma_enable               = pwdata[3];
          n.service_interrupt        = pwdata[2];
        end
        default: ;
      endcase
    end

    // fifo reads: ecp reverse data or test fifo; empty rereads last byte
    if (rd && idx == IDX_FIFO && !empty &&
        ((q.mode == MODE_ECP && dir) || q.mode == MODE_TEST)) begin
      pop    = 1'b1;
      n.last = head;
    end

    // handshake engine
    case (q.st)
      ST_IDLE: begin
        if (fifo_mode(q.mode) && !dir && !empty && !busy_s &&
            (q.mode == MODE_COMPAT || ackrev_s)) begin             // R18
          pop       = 1'b1;
          n.tx      = head;
          n.tx_addr = q.mem[q.rp][8];
          n.st      = ST_F_SETUP;
        end else if (q.mode == MODE_ECP && dir && !ackrev_s && !full) begin
          n.st = ST_R_REQ;                                          // R14 R17
        end
      end
      ST_F_SETUP: n.st = ST_F_STROBE;                               // data settles first
      ST_F_STROBE: if (busy_s) n.st = ST_F_HOLD;                    // R10 R11
      ST_F_HOLD:   if (!busy_s) n.st = ST_IDLE;                     // R10 R11
      ST_R_REQ: begin
        if (!dir) begin
          // software turned the channel round: drop the open request, else it hangs
          n.st = ST_IDLE;
        end else if (!ack_n_s) begin                                // R13
          n.rx     = pd_s;
          n.rx_cmd = !busy_s;                                       // R12
          n.st     = ST_R_TAKE;
        end
      end
      ST_R_TAKE: begin
        if (ack_n_s) begin                                          // R13
          n.st = ST_IDLE;
          if (q.rx_cmd) begin
            if (!q.rx[TAG_BIT]) begin                               // R05
              n.rle_pend = 1'b1;
              n.rle      = q.rx[6:0];
            end
          end else if (q.rle_pend) begin
            n.rle_pend = 1'b0;
            n.st       = ST_R_REPEAT;                               // R08
          end else begin
            push = 1'b1;
            pin  = {1'b0, q.rx};
          end
        end
      end
      ST_R_REPEAT: begin
        // expansion waits on a full fifo, the peripheral stays throttled
        if (!full) begin
          push = 1'b1;                                              // R08 R09
          pin  = {1'b0, q.rx};
          if (q.rle == 7'h00) n.st = ST_IDLE;
          else n.rle = q.rle - 7'h01;
        end
      end
      default: n.st = ST_IDLE;
    endcase

    // switching to spp or bidir mode flushes the fifo and stops the engine
    if (wr && idx == IDX_ECR && (pwdata[7:5] == MODE_SPP || pwdata[7:5] == MODE_BIDIR)) begin
      push       = 1'b0;
      pop        = 1'b0;
      n.wp       = '0;
      n.rp       = '0;
      n.cnt      = '0;
      n.st       = ST_IDLE;
      n.rle_pend = 1'b0;
    end else begin
      if (push) begin
        n.mem[q.wp] = pin;
        n.wp        = q.wp + PW'(1);
      end
      if (pop) n.rp = q.rp + PW'(1);
      n.cnt = q.cnt + (PW+1)'(push) - (PW+1)'(pop);                // R24
    end

    // service request: forward fifo drained or reverse fifo filled
    if (fifo_mode(q.mode) && ((!dir && empty) || (dir && full))) n.service_interrupt = 1'b1;
    n.dma_req    = q.dma_enable && !q.service_interrupt && fifo_mode(q.mode) &&
                   ((!dir && !full) || (dir && !empty));            // R06
    n.fault_intr = !q.fault_interrupt_enable_n && !fault_s;         // R21 R22

    // cable outputs
    if (fifo_mode(n.mode)) begin
      n.strobe_n = !(n.st == ST_F_STROBE);                          // R07 R10
      n.pd_out   = n.tx;
    end else begin
      n.strobe_n = !n.ctrl[CTL_STROBE];
      n.pd_out   = n.data;
    end
    if (n.mode == MODE_ECP) begin
      n.init_n      = !eff_dir(n.mode, n.ctrl);                     // R16
      n.select_in_n = 1'b1;                                         // R20
      n.pd_oe_n     = !(!eff_dir(n.mode, n.ctrl) && ackrev_s);     // R18
      if (eff_dir(n.mode, n.ctrl)) begin
        n.host_ack = !(n.st == ST_R_REQ);                           // R14
      end else begin
        n.host_ack = !n.tx_addr;                                    // R15
      end
    end else begin
      n.init_n      = n.ctrl[CTL_INIT];
      n.select_in_n = !n.ctrl[CTL_SELIN];
      n.pd_oe_n     = eff_dir(n.mode, n.ctrl);
      n.host_ack    = !n.ctrl[CTL_AUTOFD];
    end
  end

  // ---------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q                          <= '0;
      q.st                       <= ST_IDLE;
      q.data                     <= DATA_RESET;
      q.ctrl                     <= CTRL_RESET;
      q.mode                     <= MODE_RESET;
      q.fault_interrupt_enable_n <= 1'b1;
      q.strobe_n                 <= 1'b1;
      q.host_ack                 <= 1'b1;
      q.init_n                   <= 1'b0;
      q.select_in_n              <= 1'b1;
      q.s1                       <= 13'h1fff;
      q.s2                       <= 13'h1fff;
    end else begin
      q <= n;
    end
  end

  assign prdata      = {24'h000000, q.prdata};
  assign pready      = q.pready;
  assign pslverr     = q.pslverr;
  assign fault_intr  = q.fault_intr;
  assign dma_req     = q.dma_req;
  assign pd_out      = q.pd_out;
  assign pd_oe_n     = q.pd_oe_n;
  assign strobe_n    = q.strobe_n;
  assign host_ack    = q.host_ack;
  assign init_n      = q.init_n;
  assign select_in_n = q.select_in_n;
endmodule // ecp_port
`default_nettype wire

/* File: ecp_chk.sv */
// checker: apb timing, fault interrupt and reset levels of the ECP port
`timescale 1ns/10ps
`default_nettype none
module ecp_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // apb side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // cable and events
  input wire logic        fault_n,
  input wire logic        fault_intr,
  input wire logic        strobe_n,
  input wire logic        host_ack,
  input wire logic        select_in_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence setup_s; psel && !penable; endsequence
  sequence access_s; psel && penable && pready; endsequence
  chk_ready_after_setup: assert property (setup_s |=> access_s)
    else $error("no ready in the access cycle");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  chk_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside an access cycle");
  chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data wider than one port word");
  chk_err_no_data: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("refused access returned data");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  // sync is two flops plus the output register, so the cause lies 2 to 4 edges back
  chk_fault_cause: assert property (fault_intr |->
    ($past(fault_n, 2) == 1'b0 || $past(fault_n, 3) == 1'b0 || $past(fault_n, 4) == 1'b0))
    else $error("fault interrupt without a low fault input");
  chk_fault_quiet: assert property (fault_n [*6] |-> !fault_intr)
    else $error("fault interrupt while fault input high");
  chk_reset_idle: assert property ($rose(reset_n) |-> strobe_n && host_ack && select_in_n)
    else $error("cable outputs not idle after reset");
endmodule // ecp_chk
bind ecp_port ecp_chk ecp_chk_inst (.clk(clk), .reset_n(reset_n), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .fault_n(fault_n), .fault_intr(fault_intr), .strobe_n(strobe_n),
  .host_ack(host_ack), .select_in_n(select_in_n));
`default_nettype wire

/* File: ecp_periph.sv */
// peripheral model: forward sink, reverse source and direction acknowledge
`timescale 1ns/10ps
`default_nettype none
module ecp_periph (
  // clock
  input  wire logic       clk,
  // host driven lines
  input  wire logic [7:0] pd_out,
  input  wire logic       pd_oe_n,
  input  wire logic       strobe_n,
  input  wire logic       host_ack,
  input  wire logic       init_n,
  input  wire logic       select_in_n,
  // peripheral driven lines
  output logic [7:0]      pd_in,
  output var logic        ack_n,
  output var logic        busy,
  output var logic        ack_reverse_n,
  output var logic        select,
  output var logic        fault_n
);
  logic [8:0] got[$];
  logic [8:0] rq[$];
  logic       hint = 1'b0;
  int         slow = 1;
  logic       drv = 1'b0;
  logic [7:0] pd_q = 8'h00;
  // ---------------------------------------------------------------
  // cable behaviour
  // ---------------------------------------------------------------
  // a released bus shows the inverse of its last value, never a stale copy
  assign pd_in = !pd_oe_n ? pd_out : (drv ? pd_q : ~pd_q);
  initial begin
    {ack_n, busy, ack_reverse_n, select, fault_n} = 5'b10111;
    forever begin
      @(posedge clk);
      fault_n <= !hint;
      ack_reverse_n <= init_n;
      if (!strobe_n && !busy) begin
        got.push_back({host_ack, pd_out});
        repeat (slow) @(posedge clk);
        busy <= 1'b1;
        while (!strobe_n) @(posedge clk);
        repeat (slow) @(posedge clk);
        busy <= 1'b0;
      end else if (!init_n && !ack_reverse_n && !host_ack && select_in_n && rq.size() > 0) begin
        {busy, pd_q} <= rq.pop_front();
        drv <= 1'b1;
        repeat (slow) @(posedge clk);
        ack_n <= 1'b0;
        while (!host_ack) @(posedge clk);
        ack_n <= 1'b1;
        busy <= 1'b0;
        drv <= 1'b0;
      end
    end
  end
endmodule // ecp_periph
`default_nettype wire

/* File: ecp_parallel_port_link_test.sv */
// testbench: register access, shared fifo, forward and reverse ECP transfers
`timescale 1ns/10ps
`default_nettype none
module ecp_parallel_port_link_test;
  import ecp_pkg::*;
  localparam logic [12:0] A_DATA = {IDX_DATA, 2'b00};
  localparam logic [12:0] A_STAT = {IDX_STATUS, 2'b00};
  localparam logic [12:0] A_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [12:0] A_FIFO = {IDX_FIFO, 2'b00};
  localparam logic [12:0] A_CFGB = {IDX_CFGB, 2'b00};
  localparam logic [12:0] A_ECR  = {IDX_ECR, 2'b00};
  logic        clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [12:0] paddr = 13'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [2:0]  cfg_irq = 3'h5, cfg_dma = 3'h2;
  logic [7:0]  pd_in, pd_out, q;
  logic        pready, pslverr, fault_intr, dma_req, pd_oe_n, strobe_n, host_ack, e;
  logic        init_n, select_in_n, ack_n, busy, ack_reverse_n, select, fault_n;
  int          mismatches = 0;
  int          compares = 0;
  ecp_port ecp_port_inst (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cfg_irq(cfg_irq), .cfg_dma(cfg_dma), .fault_intr(fault_intr),
    .dma_req(dma_req), .pd_in(pd_in), .pd_out(pd_out), .pd_oe_n(pd_oe_n),
    .strobe_n(strobe_n), .host_ack(host_ack), .init_n(init_n), .select_in_n(select_in_n),
    .ack_n(ack_n), .busy(busy), .ack_reverse_n(ack_reverse_n), .select(select),
    .fault_n(fault_n));
  ecp_periph ecp_periph_inst (.clk(clk), .pd_out(pd_out), .pd_oe_n(pd_oe_n),
    .strobe_n(strobe_n), .host_ack(host_ack), .init_n(init_n), .select_in_n(select_in_n),
    .pd_in(pd_in), .ack_n(ack_n), .busy(busy), .ack_reverse_n(ack_reverse_n),
    .select(select), .fault_n(fault_n));
  // ---------------------------------------------------------------
  // clock, tasks
  // ---------------------------------------------------------------
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // the idle edge first keeps two transfers from driving psel in one time step
  task automatic apb(input logic wr, input logic [12:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) mismatches++;
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [12:0] a, input logic [8:0] exp);
    apb(1'b0, a, 8'h00);
    check({e, q}, exp);
  endtask
  task automatic wait_got(input int n);
    int t;
    t = 0;
    while (ecp_periph_inst.got.size() < n && t < 3000) begin
      @(posedge clk);
      t++;
    end
    check(9'(ecp_periph_inst.got.size()), 9'(n));
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    test_done();
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge clk);
    rd(A_ECR, 9'h011);
    rd(A_STAT, 9'h0d8);
    rd(A_CTRL, 9'h000);
    rd(13'h000c, 9'h100);
    rd(A_CFGB, 9'h100);
    apb(1'b1, A_CTRL, 8'hff);
    rd(A_CTRL, 9'h03f);
    apb(1'b1, A_CTRL, 8'h04);
    apb(1'b1, A_ECR, 8'hf0);
    rd(A_FIFO, 9'h010);
    rd(A_CFGB, {3'b000, cfg_irq, cfg_dma});
    apb(1'b1, A_ECR, 8'hd0);
    for (int i = 0; i <= FIFO_DEPTH; i++) begin
      apb(1'b1, A_FIFO, 8'(i + 48));
    end
    rd(A_ECR, 9'h0d2);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      rd(A_FIFO, 9'(i + 48));
    end
    rd(A_ECR, 9'h0d1);
    rd(A_FIFO, 9'h03f);
    // slow peripheral in compatibility fifo mode
    ecp_periph_inst.got.delete();
    ecp_periph_inst.slow = 3;
    apb(1'b1, A_ECR, 8'h50);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, A_FIFO, 8'(8'ha0 + i));
    end
    wait_got(3);
    for (int i = 0; i < 3; i++) begin
      check(ecp_periph_inst.got.pop_front(), 9'(9'h1a0 + i));
    end
    rd(A_ECR, 9'h055);
    ecp_periph_inst.slow = 1;
    apb(1'b1, A_ECR, 8'h70);
    apb(1'b1, A_DATA, 8'h85);
    apb(1'b1, A_FIFO, 8'h3c);
    apb(1'b1, A_DATA, 8'h02);
    wait_got(3);
    check(ecp_periph_inst.got.pop_front(), 9'h085);
    check(ecp_periph_inst.got.pop_front(), 9'h13c);
    check(ecp_periph_inst.got.pop_front(), 9'h002);
    check({7'h0, select_in_n, init_n}, 9'h003);
    // reverse: count 2, data, channel address, data
    ecp_periph_inst.rq = '{9'h002, 9'h15a, 9'h081, 9'h111};
    apb(1'b1, A_CTRL, 8'h20);
    for (int t = 0; t < 3000 && (ecp_periph_inst.rq.size() > 0 || ack_n !== 1'b1); t++) begin
      @(posedge clk);
    end
    repeat (20) @(posedge clk);
    check({7'h0, init_n, pd_oe_n}, 9'h001);
    apb(1'b1, A_ECR, 8'h78);
    repeat (2) @(posedge clk);
    check({8'h0, dma_req}, 9'h001);
    for (int i = 0; i < 3; i++) begin
      rd(A_FIFO, 9'h05a);
    end
    rd(A_FIFO, 9'h011);
    repeat (2) @(posedge clk);
    check({8'h0, dma_req}, 9'h000);
    apb(1'b1, A_ECR, 8'h60);
    // the request hint is only legal in the forward direction
    apb(1'b1, A_CTRL, 8'h04);
    ecp_periph_inst.hint = 1'b1;
    repeat (8) @(posedge clk);
    check({8'h0, fault_intr}, 9'h001);
    rd(A_STAT, 9'h0f0);
    ecp_periph_inst.hint = 1'b0;
    repeat (8) @(posedge clk);
    check({8'h0, fault_intr}, 9'h000);
    test_done();
  end
endmodule // ecp_parallel_port_link_test
`default_nettype wire
